//--- hdl/hmp_pattern_regs.sv
`timescale 1ns/10ps
module hmp_pattern_regs
(
    input wire logic clk_sys, // 100 MHz clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [hmp_pkg::ADDR_W-1:0] avs_address, // Byte address
    input wire logic avs_read, // Read request
    input wire logic avs_write, // Write request
    input wire logic [31:0] avs_writedata, // Write data
    input wire logic [3:0] avs_byteenable, // Byte lanes
    output logic [31:0] avs_readdata, // Read data
    output logic avs_waitrequest, // Stall
    input wire logic [2:0] hall_sensor_input, // Hall sensors 2..0
    input wire logic [7:1] trigger_in, // Next multichannel events
    input wire logic [3:1] sync_in, // Modulation sync events
    input wire logic [5:0] pwm_in, // PWM per output, pattern order
    output logic ch2_complement_out, // Modulated output
    output logic ch2_out, // Modulated output
    output logic ch1_complement_out, // Modulated output
    output logic ch1_out, // Modulated output
    output logic ch0_complement_out, // Modulated output
    output logic ch0_out, // Modulated output
    output logic correct_hall_event, // One-cycle pulse
    output logic wrong_hall_event, // One-cycle pulse
    output logic mcm_transfer, // One-cycle pulse on hardware transfer
    output logic irq // Level interrupt
);
    logic [2:0] current_hall_shadow;
    logic [2:0] expected_hall_shadow;
    logic [5:0] modulation_shadow;
    logic [2:0] current_hall_pattern;
    logic [2:0] expected_hall_pattern;
    logic [5:0] modulation_pattern;
    logic reminder;
    logic [2:0] switch_trigger_select;
    logic [1:0] switch_sync_select;
    logic multichannel_enable;
    logic idle_enable;
    logic [hmp_pkg::ST_W-1:0] status;
    logic [hmp_pkg::ST_W-1:0] mask;
    logic [2:0] hall_prev;
    logic hall_edge;
    logic [2:0] hall_sample;
    logic next_che;
    logic next_whe;
    logic hw_request;
    logic sync_ok;
    logic hw_transfer;
    logic acc_write;
    logic [15:0] acc_index;
    logic [15:0] wdata;
    logic [15:0] read_value;
    logic wr_shadow;
    logic wr_control;
    logic wr_status;
    logic wr_mask;
    logic hall_req_write;
    logic mod_req_write;
    logic match_current;
    logic match_expected;
    logic [hmp_pkg::ST_W-1:0] status_set;
    logic [hmp_pkg::ST_W-1:0] status_clear;
    logic [hmp_pkg::ST_W-1:0] next_status;

    // Common layout of the shadow and active words
    function automatic logic [15:0] pack_patterns(input logic [2:0] cur,
                                                  input logic [2:0] exp,
                                                  input logic [5:0] pat);
        pack_patterns = 16'h0000;
        pack_patterns[hmp_pkg::CUR_LSB +: 3] = cur;
        pack_patterns[hmp_pkg::EXP_LSB +: 3] = exp;
        pack_patterns[hmp_pkg::MOD_LSB +: 6] = pat;
    endfunction : pack_patterns

    function automatic logic addr_is(input logic [hmp_pkg::ADDR_W-1:0] addr,
                                     input logic [15:0] index);
        addr_is = (addr == {index, 2'b00});
    endfunction : addr_is

    assign acc_index = avs_address[hmp_pkg::ADDR_W-1:2];
    assign acc_write = avs_write && !avs_waitrequest && (avs_address[1:0] == 2'b00);
    assign wdata = {avs_byteenable[1] ? avs_writedata[15:8] : 8'h00,
                    avs_byteenable[0] ? avs_writedata[7:0] : 8'h00};

    // Register hits of an accepted write
    assign wr_shadow = acc_write && (acc_index == hmp_pkg::IDX_SHADOW);
    assign wr_control = acc_write && (acc_index == hmp_pkg::IDX_CONTROL);
    assign wr_status = acc_write && (acc_index == hmp_pkg::IDX_STATUS);
    assign wr_mask = acc_write && (acc_index == hmp_pkg::IDX_MASK);
    // Request bits act only on the write that carries them
    assign hall_req_write = wr_shadow && wdata[hmp_pkg::HALL_REQ_BIT];
    assign mod_req_write = wr_shadow && wdata[hmp_pkg::MOD_REQ_BIT];

    // One wait state on every access
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            avs_waitrequest <= 1'b1;
        else
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end

    // Request bits and unused positions read as zero
    always_comb
    begin
        read_value = 16'h0000;
        if (addr_is(avs_address, hmp_pkg::IDX_SHADOW))
        begin
            read_value = pack_patterns(current_hall_shadow, expected_hall_shadow,
                                       modulation_shadow);
        end
        else if (addr_is(avs_address, hmp_pkg::IDX_ACTIVE))
        begin
            read_value = pack_patterns(current_hall_pattern, expected_hall_pattern,
                                       modulation_pattern);
            read_value[hmp_pkg::REMIND_BIT] = reminder;
        end
        else if (addr_is(avs_address, hmp_pkg::IDX_CONTROL))
        begin
            read_value[hmp_pkg::TRIG_SEL_LSB +: 3] = switch_trigger_select;
            read_value[hmp_pkg::SYNC_SEL_LSB +: 2] = switch_sync_select;
            read_value[hmp_pkg::MCM_EN_BIT] = multichannel_enable;
            read_value[hmp_pkg::IDLE_EN_BIT] = idle_enable;
        end
        else if (addr_is(avs_address, hmp_pkg::IDX_STATUS))
            read_value[hmp_pkg::ST_W-1:0] = status;
        else if (addr_is(avs_address, hmp_pkg::IDX_MASK))
            read_value[hmp_pkg::ST_W-1:0] = mask;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            avs_readdata <= 32'h0000_0000;
        else if (avs_read && avs_waitrequest)
            avs_readdata <= {16'h0000, read_value};
    end

    // Shadow fields
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            current_hall_shadow <= hmp_pkg::SHADOW_RST[hmp_pkg::CUR_LSB +: 3];
            expected_hall_shadow <= hmp_pkg::SHADOW_RST[hmp_pkg::EXP_LSB +: 3];
            modulation_shadow <= hmp_pkg::SHADOW_RST[hmp_pkg::MOD_LSB +: 6];
        end
        else if (wr_shadow)
        begin
            current_hall_shadow <= wdata[hmp_pkg::CUR_LSB +: 3];
            expected_hall_shadow <= wdata[hmp_pkg::EXP_LSB +: 3];
            modulation_shadow <= wdata[hmp_pkg::MOD_LSB +: 6];
        end
    end

    // Control, mask and own settings
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            switch_trigger_select <= hmp_pkg::CONTROL_RST[hmp_pkg::TRIG_SEL_LSB +: 3];
            switch_sync_select <= hmp_pkg::CONTROL_RST[hmp_pkg::SYNC_SEL_LSB +: 2];
            multichannel_enable <= hmp_pkg::CONTROL_RST[hmp_pkg::MCM_EN_BIT];
            idle_enable <= hmp_pkg::CONTROL_RST[hmp_pkg::IDLE_EN_BIT];
            mask <= hmp_pkg::MASK_RST;
        end
        else
        begin
            if (wr_control)
            begin
                switch_trigger_select <= wdata[hmp_pkg::TRIG_SEL_LSB +: 3];
                switch_sync_select <= wdata[hmp_pkg::SYNC_SEL_LSB +: 2];
                multichannel_enable <= wdata[hmp_pkg::MCM_EN_BIT];
                idle_enable <= wdata[hmp_pkg::IDLE_EN_BIT];
            end
            if (wr_mask)
                mask <= wdata[hmp_pkg::ST_W-1:0];
        end
    end

    // Edge detection and compare, one cycle after the edge
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            hall_prev <= 3'h0;
            hall_edge <= 1'b0;
            hall_sample <= 3'h0;
        end
        else
        begin
            hall_prev <= hall_sensor_input;
            hall_edge <= (hall_sensor_input != hall_prev);
            hall_sample <= hall_sensor_input;
        end
    end

    // Compare against the patterns in force
    assign match_current = (hall_sample == current_hall_pattern);
    assign match_expected = (hall_sample == expected_hall_pattern);

    // A return to the current pattern is taken as a spike
    always_comb
    begin
        next_che = 1'b0;
        next_whe = 1'b0;
        if (hall_edge)
        begin
            if (match_current)
                next_che = 1'b0;
            else if (match_expected)
                next_che = 1'b1;
            else
                next_whe = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            correct_hall_event <= 1'b0;
            wrong_hall_event <= 1'b0;
        end
        else
        begin
            correct_hall_event <= next_che;
            wrong_hall_event <= next_whe;
        end
    end

    // Active Hall patterns; software request wins over hardware
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            current_hall_pattern <= hmp_pkg::ACTIVE_RST[hmp_pkg::CUR_LSB +: 3];
            expected_hall_pattern <= hmp_pkg::ACTIVE_RST[hmp_pkg::EXP_LSB +: 3];
        end
        else if (hall_req_write)
        begin
            current_hall_pattern <= wdata[hmp_pkg::CUR_LSB +: 3];
            expected_hall_pattern <= wdata[hmp_pkg::EXP_LSB +: 3];
        end
        else if (next_che)
        begin
            current_hall_pattern <= current_hall_shadow;
            expected_hall_pattern <= expected_hall_shadow;
        end
    end

    // Hardware transfer request and synchronisation
    always_comb
    begin
        hw_request = 1'b0;
        if (multichannel_enable)
        begin
            if (switch_trigger_select == hmp_pkg::TRIG_CHE)
                hw_request = next_che;
            else if (switch_trigger_select != hmp_pkg::TRIG_NONE)
                hw_request = trigger_in[switch_trigger_select];
        end
    end

    // Sync gate; select zero lets the transfer through at once
    always_comb
    begin
        sync_ok = 1'b1;
        if (switch_sync_select != hmp_pkg::SYNC_NONE)
            sync_ok = sync_in[switch_sync_select];
    end

    assign hw_transfer = multichannel_enable && (reminder || hw_request) && sync_ok;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reminder <= 1'b0;
        else if (!multichannel_enable || hw_transfer)
            reminder <= 1'b0;
        else if (hw_request)
            reminder <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            mcm_transfer <= 1'b0;
        else
            mcm_transfer <= hw_transfer;
    end

    // Active modulation pattern; idle overrides everything
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            modulation_pattern <= hmp_pkg::ACTIVE_RST[hmp_pkg::MOD_LSB +: 6];
        else if (status[hmp_pkg::ST_IDLE])
            modulation_pattern <= 6'h00;
        else if (mod_req_write)
            modulation_pattern <= wdata[hmp_pkg::MOD_LSB +: 6];
        else if (hw_transfer)
            modulation_pattern <= modulation_shadow;
    end

    // Set sources, one per sticky flag
    always_comb
    begin
        status_set = '0;
        status_set[hmp_pkg::ST_CHE] = next_che;
        status_set[hmp_pkg::ST_WHE] = next_whe;
        status_set[hmp_pkg::ST_STR] = hw_transfer;
        status_set[hmp_pkg::ST_IDLE] = next_whe && idle_enable;
    end

    // Write one to clear; a set in the same cycle wins
    always_comb
    begin
        status_clear = '0;
        if (wr_status)
            status_clear = wdata[hmp_pkg::ST_W-1:0];
        next_status = (status & ~status_clear) | status_set;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            status <= hmp_pkg::STATUS_RST;
        else
            status <= next_status;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(status & mask);
    end

    // Output gating by pattern
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            {ch2_complement_out, ch2_out, ch1_complement_out} <= 3'h0;
            {ch1_out, ch0_complement_out, ch0_out} <= 3'h0;
        end
        else
        begin
            ch2_complement_out <= modulation_pattern[5] & pwm_in[5];
            ch2_out <= modulation_pattern[4] & pwm_in[4];
            ch1_complement_out <= modulation_pattern[3] & pwm_in[3];
            ch1_out <= modulation_pattern[2] & pwm_in[2];
            ch0_complement_out <= modulation_pattern[1] & pwm_in[1];
            ch0_out <= modulation_pattern[0] & pwm_in[0];
        end
    end
endmodule : hmp_pattern_regs

//--- shared/hmp_pkg.sv
package hmp_pkg;
    // Register indices; byte address is four times the index
    localparam logic [15:0] IDX_SHADOW = 16'hE8CA;
    localparam logic [15:0] IDX_ACTIVE = 16'hE8CC;
    localparam logic [15:0] IDX_CONTROL = 16'hE8CE;
    localparam logic [15:0] IDX_STATUS = 16'hE8D0;
    localparam logic [15:0] IDX_MASK = 16'hE8D2;
    localparam int ADDR_W = 18;
    // Shadow and active field positions
    localparam int HALL_REQ_BIT = 15;
    localparam int CUR_LSB = 11;
    localparam int EXP_LSB = 8;
    localparam int MOD_REQ_BIT = 7;
    localparam int REMIND_BIT = 6;
    localparam int MOD_LSB = 0;
    // Control field positions
    localparam int TRIG_SEL_LSB = 0;
    localparam int SYNC_SEL_LSB = 4;
    localparam int MCM_EN_BIT = 8;
    localparam int IDLE_EN_BIT = 9;
    // Status and mask bit positions
    localparam int ST_CHE = 0;
    localparam int ST_WHE = 1;
    localparam int ST_STR = 2;
    localparam int ST_IDLE = 3;
    localparam int ST_W = 4;
    // Reset values
    localparam logic [15:0] SHADOW_RST = 16'h0000;
    localparam logic [15:0] ACTIVE_RST = 16'h0000;
    localparam logic [15:0] CONTROL_RST = 16'h0000;
    localparam logic [3:0] STATUS_RST = 4'h0;
    localparam logic [3:0] MASK_RST = 4'h0;
    // Trigger and sync select codes
    localparam logic [2:0] TRIG_NONE = 3'h0;
    localparam logic [2:0] TRIG_CHE = 3'h1;
    localparam logic [1:0] SYNC_NONE = 2'h0;
endpackage : hmp_pkg

//--- verification/hmp_hall_model.sv
`timescale 1ns/10ps
module hmp_hall_model
(
    input wire logic clk_sys, // Clock
    output logic [2:0] hall_sensor_input, // Sensor levels, bit i = sensor i
    output logic [5:0] pwm_in // Alternating PWM levels
);
    initial hall_sensor_input = 3'h0;
    initial pwm_in = 6'h0F;
    always @(posedge clk_sys)
    begin
        pwm_in <= ~pwm_in;
    end
    task automatic drive(input logic [2:0] v);
        hall_sensor_input <= v;
    endtask : drive
endmodule : hmp_hall_model

//--- verification/hmp_pattern_regs_assertions.sv
`timescale 1ns/10ps
module hmp_chk
(
    input wire logic clk_sys, // Clock
    input wire logic rst, // Reset
    input wire logic [hmp_pkg::ADDR_W-1:0] avs_address, // Address
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic [31:0] avs_readdata, // Read data
    input wire logic avs_waitrequest, // Stall
    input wire logic [2:0] hall_sensor_input, // Sensors
    input wire logic [5:0] pwm_in, // PWM
    input wire logic ch2_complement_out, // Output
    input wire logic ch2_out, // Output
    input wire logic ch1_complement_out, // Output
    input wire logic ch1_out, // Output
    input wire logic ch0_complement_out, // Output
    input wire logic ch0_out, // Output
    input wire logic correct_hall_event, // Pulse
    input wire logic wrong_hall_event, // Pulse
    input wire logic irq // Interrupt
);
    logic [2:0] hd1;
    logic [2:0] hd2;
    logic [2:0] hd3;
    logic [2:0] hd4;
    always_ff @(posedge clk_sys)
    begin
        hd1 <= hall_sensor_input;
        hd2 <= hd1;
        hd3 <= hd2;
        hd4 <= hd3;
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence s_shadow_read;
        avs_read && avs_waitrequest && avs_address == {hmp_pkg::IDX_SHADOW, 2'b00};
    endsequence
    sequence s_read_answer;
        !avs_waitrequest && avs_readdata[15:14] == 2'b00 && !avs_readdata[7];
    endsequence
    a_wait_one_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_request_answer: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("access not answered");
    a_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest && !irq
        && !correct_hall_event && !wrong_hall_event) else $error("outputs after reset");
    a_events_exclusive: assert property (!(correct_hall_event && wrong_hall_event))
        else $error("both hall events");
    a_event_cause: assert property ((correct_hall_event || wrong_hall_event) |->
        hd1 != hd2 || hd2 != hd3 || hd3 != hd4) else $error("event without edge");
    a_output_gate: assert property (({ch2_complement_out, ch2_out, ch1_complement_out,
        ch1_out, ch0_complement_out, ch0_out} & ~$past(pwm_in)) == 6'h00)
        else $error("output without pwm");
    a_upper_zero: assert property (avs_readdata[31:16] == 16'h0000)
        else $error("upper read data set");
    a_shadow_read: assert property (s_shadow_read |=> s_read_answer)
        else $error("request bits read back");
endmodule : hmp_chk
bind hmp_pattern_regs hmp_chk u_chk (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hall_sensor_input(hall_sensor_input), .pwm_in(pwm_in),
    .ch2_complement_out(ch2_complement_out), .ch2_out(ch2_out), .ch1_out(ch1_out),
    .ch1_complement_out(ch1_complement_out), .ch0_complement_out(ch0_complement_out),
    .ch0_out(ch0_out), .correct_hall_event(correct_hall_event),
    .wrong_hall_event(wrong_hall_event), .irq(irq));

//--- verification/test_hmp_pattern_regs.sv
`timescale 1ns/10ps
module test_hmp_pattern_regs;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [hmp_pkg::ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h3;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] hall_sensor_input;
    logic [7:1] trigger_in = 7'h00;
    logic [3:1] sync_in = 3'h0;
    logic [5:0] pwm_in;
    wire logic [5:0] outs;
    logic correct_hall_event;
    logic wrong_hall_event;
    logic mcm_transfer;
    logic irq;
    logic [15:0] q;
    logic [5:0] pv;
    int mismatches = 0;
    int checks_done = 0;
    int n_che = 0;
    int n_whe = 0;
    int n_mcm = 0;
    int cycles = 0;
    hmp_hall_model hall_m (.clk_sys(clk_sys), .hall_sensor_input(hall_sensor_input),
        .pwm_in(pwm_in));
    hmp_pattern_regs DUT (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .hall_sensor_input(hall_sensor_input),
        .trigger_in(trigger_in), .sync_in(sync_in), .pwm_in(pwm_in),
        .ch2_complement_out(outs[5]), .ch2_out(outs[4]), .ch1_complement_out(outs[3]),
        .ch1_out(outs[2]), .ch0_complement_out(outs[1]), .ch0_out(outs[0]),
        .correct_hall_event(correct_hall_event), .wrong_hall_event(wrong_hall_event),
        .mcm_transfer(mcm_transfer), .irq(irq));
    always #5 clk_sys = ~clk_sys;
    task give_verdict;
        if (mismatches == 0 && checks_done > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    always @(posedge clk_sys)
    begin
        cycles++;
        n_che += int'(correct_hall_event === 1'b1);
        n_whe += int'(wrong_hall_event === 1'b1);
        n_mcm += int'(mcm_transfer === 1'b1);
        if (cycles == 3000)
        begin
            mismatches++;
            give_verdict();
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task bus(input logic w, input logic [15:0] idx, input logic [15:0] d);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {16'h0000, d};
        avs_write <= w;
        avs_read <= ~w;
        @(negedge clk_sys);
        while (avs_waitrequest !== 1'b0)
            @(negedge clk_sys);
        @(posedge clk_sys);
        q = avs_readdata[15:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task rdc(input logic [15:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 16'h0000);
        chk(q, exp);
    endtask : rdc
    task step(input logic [2:0] v);
        hall_m.drive(v);
        repeat (8) @(posedge clk_sys);
    endtask : step
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        rdc(hmp_pkg::IDX_SHADOW, 16'h0000);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h0000);
        rdc(16'h0001, 16'h0000);
        bus(1'b1, hmp_pkg::IDX_SHADOW, 16'h6C6A);
        rdc(hmp_pkg::IDX_SHADOW, 16'h2C2A);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h0000);
        bus(1'b1, hmp_pkg::IDX_SHADOW, 16'hACAA);
        rdc(hmp_pkg::IDX_SHADOW, 16'h2C2A);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h2C2A);
        bus(1'b1, hmp_pkg::IDX_ACTIVE, 16'hFFFF);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h2C2A);
        bus(1'b1, hmp_pkg::IDX_SHADOW, 16'h262A);
        step(3'h5);
        chk(16'(n_che + n_whe), 16'h0000);
        step(3'h4);
        chk(16'(n_che), 16'h0001);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h262A);
        step(3'h1);
        chk(16'(n_whe), 16'h0001);
        rdc(hmp_pkg::IDX_STATUS, 16'h0003);
        bus(1'b1, hmp_pkg::IDX_MASK, 16'h0002);
        repeat (2) @(posedge clk_sys);
        chk({15'h0000, irq}, 16'h0001);
        bus(1'b1, hmp_pkg::IDX_STATUS, 16'h0002);
        repeat (2) @(posedge clk_sys);
        chk({15'h0000, irq}, 16'h0000);
        rdc(hmp_pkg::IDX_STATUS, 16'h0001);
        bus(1'b1, hmp_pkg::IDX_STATUS, 16'h0001);
        bus(1'b1, hmp_pkg::IDX_CONTROL, 16'h0001);
        bus(1'b1, hmp_pkg::IDX_SHADOW, 16'h3215);
        step(3'h6);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h322A);
        chk(16'(n_mcm), 16'h0000);
        bus(1'b1, hmp_pkg::IDX_CONTROL, 16'h0101);
        bus(1'b1, hmp_pkg::IDX_SHADOW, 16'h1315);
        step(3'h2);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h1315);
        chk(16'(n_mcm), 16'h0001);
        @(negedge clk_sys);
        pv = pwm_in;
        repeat (2)
        begin
            @(negedge clk_sys);
            chk({10'h000, outs}, {10'h000, 6'h15 & pv});
            pv = pwm_in;
        end
        bus(1'b1, hmp_pkg::IDX_CONTROL, 16'h0301);
        step(3'h5);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h1300);
        rdc(hmp_pkg::IDX_STATUS, 16'h000F);
        bus(1'b1, hmp_pkg::IDX_SHADOW, 16'h1395);
        rdc(hmp_pkg::IDX_ACTIVE, 16'h1300);
        chk(16'(n_whe), 16'h0002);
        give_verdict();
    end
endmodule : test_hmp_pattern_regs
